// ==== dv/hfp_host_model.sv ====
`timescale 1ns/10ps

// Behavioural host CPU that splits each word into two half-word cycles.
module hfp_host_model
  import hfp_pkg::*;
(
  input  wire logic               core_clk,     // System clock.
  output logic                    hostRead,     // Half-word read strobe.
  output logic                    hostWrite,    // Half-word write strobe.
  output logic      [HOST_AW-1:0] hostAddr,     // Byte address.
  output logic      [15:0]        hostWrData,   // Write half-word.
  input  wire logic [15:0]        hostRdData,   // Read half-word.
  input  wire logic               hostRdValid   // Read answer pulse.
);
  // The bus starts idle so nothing is taken before reset ends.
  initial begin
    hostRead   = 1'b0;
    hostWrite  = 1'b0;
    hostAddr   = 8'h00;
    hostWrData = 16'h0000;
  end

  // One write half, strobe high for exactly one taken edge.
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    hostWrite  <= 1'b1;
    hostAddr   <= a;
    hostWrData <= d;
    @(posedge core_clk);
    hostWrite  <= 1'b0;
    hostWrData <= ~d;  // Released data shows the inverse, not a stale copy.
  endtask

  // One read half; the answer is sampled mid-cycle after the taken edge.
  task automatic rd16(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge core_clk);
    hostRead <= 1'b1;
    hostAddr <= a;
    @(posedge core_clk);
    hostRead <= 1'b0;
    @(negedge core_clk);
    ok = hostRdValid;
    d  = hostRdData;
  endtask

  // Callers put zero in reserved bits and never address reserved words.
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    wr16({a[7:2], 2'b00}, d[15:0]);
    wr16({a[7:2], 2'b10}, d[31:16]);
  endtask

  // Whole-word read, lower half first; ok is low if either answer failed.
  task automatic rd32(input logic [7:0] a, output logic [31:0] d, output logic ok);
    logic okLo;
    logic okHi;
    rd16({a[7:2], 2'b00}, d[15:0], okLo);
    rd16({a[7:2], 2'b10}, d[31:16], okHi);
    ok = okLo & okHi;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps

`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

// Self-checking bench of the host FIFO port block.
module tb
  import hfp_pkg::*;
;
  logic        core_clk, reset_n, softResetIn, linkEvent, linkUp, clkEn;  // Clock and controls.
  logic        rxStsPush, rxDataPush, txStsPush, txDataTake;  // FIFO side strobes.
  logic [31:0] rxStsIn, rxDataIn, txStsIn, txDataOut;  // FIFO side words.
  logic        hostRead, hostWrite, hostRdValid, ok;  // Host strobes and answer.
  logic        rxStsFull, rxDataFull, txStsFull, txDataEmpty, keepOut;  // Levels.
  logic [7:0]  hostAddr;  // Host byte address.
  logic [15:0] hostWrData, hostRdData;  // Host half-words.
  logic [31:0] seed, rd, a, b;  // Random state and scratch words.
  logic [31:0] q[$];  // Expected FIFO contents.
  int          failCount, compares;  // Mismatch and comparison counts.

  hfp_port i_hfp_port (.core_clk, .reset_n, .clkEn, .softResetIn, .hostRead,
    .hostWrite, .hostAddr, .hostWrData, .hostRdData, .hostRdValid, .rxStsPush, .rxStsIn,
    .rxStsFull, .rxDataPush, .rxDataIn, .rxDataFull, .txStsPush, .txStsIn, .txStsFull,
    .txDataEmpty, .txDataOut, .txDataTake, .linkEvent, .linkUp, .keepOut);

  hfp_host_model host (.core_clk, .hostRead, .hostWrite, .hostAddr, .hostWrData,
    .hostRdData, .hostRdValid);

  // Free-running 20 MHz clock.
  always #25 core_clk = ~core_clk;

  // Xorshift generator; the fixed start keeps runs repeatable.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Pushes one word: 0 receive data, 1 receive status, 2 transmit status.
  task automatic push(input int which, input logic [31:0] v);
    @(posedge core_clk);
    rxDataPush <= (which == 0);
    rxStsPush  <= (which == 1);
    txStsPush  <= (which == 2);
    rxDataIn   <= v;
    rxStsIn    <= v;
    txStsIn    <= v;
    @(posedge core_clk);
    rxDataPush <= 1'b0;
    rxStsPush  <= 1'b0;
    txStsPush  <= 1'b0;
  endtask

  // Reads a word and compares the bits under the mask.
  task automatic rdChk(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m = '1);
    host.rd32(ad, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(rd & m, e)
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrapUp();
    $display("compares %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of a few hundred cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    failCount++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrapUp();
  end

  // Main sequence of scenarios.
  initial begin
    {core_clk, reset_n, softResetIn, linkEvent, rxStsPush, rxDataPush} = '0;
    {txStsPush, txDataTake, rxStsIn, rxDataIn, txStsIn} = '0;
    linkUp = 1'b1;
    clkEn = 1'b1;
    seed = 32'h6;
    failCount = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK({txDataEmpty, rxDataFull, rxStsFull, txStsFull, keepOut}, 5'b10000)
    $display("test defaults done");
    // Transmit data: lower half alone must not push; aliases reach one FIFO.
    q.push_back(xs());
    host.wr16(OFS_TXDATA, q[0][15:0]);
    @(negedge core_clk);
    `CHK(txDataEmpty, 1'b1)
    host.wr16(OFS_TXDATA + 8'h02, q[0][31:16]);
    for (int i = 1; i < 4; i++) begin
      q.push_back(xs());
      host.wr32(OFS_TXDATA + 8'(4 * ((i == 3) ? 15 : xs() % 16)), q[i]);
    end
    rdChk(OFS_TXDATA, 32'h0);
    rdChk(OFS_CMD, 32'h0);
    host.wr32(OFS_ID, xs());
    rdChk(OFS_ID, CHIP_ID);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      `CHK(txDataOut, q[i])
      @(posedge core_clk);
      txDataTake <= 1'b1;
      @(posedge core_clk);
      txDataTake <= 1'b0;
    end
    @(negedge core_clk);
    `CHK(txDataEmpty, 1'b1)
    q.delete();
    $display("test transmit data done");
    // Receive data read through random aliases, in order, then empty.
    for (int i = 0; i < 4; i++) begin
      q.push_back(xs());
      push(0, q[i]);
    end
    for (int i = 0; i < 4; i++) rdChk(8'(4 * ((i == 0) ? 15 : xs() % 16)), q[i]);
    rdChk(OFS_RXDATA, 32'h0);
    q.delete();
    $display("test receive data done");
    // Receive status: writes refused, peek keeps the head, pop removes it.
    a = xs();
    b = xs();
    push(1, a);
    push(1, b);
    host.wr32(OFS_RXSTS, xs());
    rdChk(OFS_RXPEEK, a);
    rdChk(OFS_RXPEEK, a);
    rdChk(OFS_RXSTS, a);
    rdChk(OFS_RXSTS, b);
    $display("test receive status done");
    // Transmit status: overfill past 16, then peek and pop.
    for (int i = 0; i < 17; i++) begin
      q.push_back(xs());
      push(2, q[i]);
    end
    @(negedge core_clk);
    `CHK(txStsFull, 1'b1)
    rdChk(OFS_TXPEEK, q[0]);
    rdChk(OFS_TXSTS, q[0]);
    rdChk(OFS_TXPEEK, q[1]);
    $display("test transmit status done");
    // Data limit of 2, status limit of 1, keep bit set; third word overruns.
    host.wr32(OFS_CTRL, 32'h0001_0202);
    for (int i = 0; i < 3; i++) push(0, xs());
    push(1, xs());
    @(negedge core_clk);
    `CHK({keepOut, rxDataFull, rxStsFull}, 3'b111)
    @(posedge core_clk);
    linkEvent <= 1'b1;
    linkUp    <= 1'b0;
    @(posedge core_clk);
    linkEvent <= 1'b0;
    linkUp    <= 1'b1;
    rdChk(OFS_FLAGS, 32'h7, 32'hF);
    rdChk(OFS_FLAGS, 32'h9, 32'hF);
    host.wr32(OFS_FLAGS, 32'h0);
    rdChk(OFS_FLAGS, 32'h9, 32'hF);
    host.wr32(OFS_FLAGS, 32'h1);
    rdChk(OFS_FLAGS, 32'h8, 32'hF);
    // A push into the full data FIFO while frozen must not raise the overrun.
    @(posedge core_clk);
    clkEn <= 1'b0;
    push(0, xs());
    @(posedge core_clk);
    clkEn <= 1'b1;
    rdChk(OFS_FLAGS, 32'h8, 32'hF);
    $display("test flags done");
    // Software reset keeps the keep bit, restores limits and empties FIFOs.
    @(posedge core_clk);
    softResetIn <= 1'b1;
    @(posedge core_clk);
    softResetIn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdChk(OFS_RXDATA, 32'h0);
    push(0, xs());
    push(0, xs());
    @(negedge core_clk);
    `CHK({keepOut, rxDataFull, rxStsFull}, 3'b100)
    // Flush commands empty both data FIFOs.
    host.wr32(OFS_TXDATA, xs());
    host.wr32(OFS_CMD, 32'h3);
    rdChk(OFS_RXDATA, 32'h0);
    `CHK(txDataEmpty, 1'b1)
    // Soft reset through the control word undoes the limits written with it.
    host.wr32(OFS_CTRL, 32'h0000_0203);
    push(0, xs());
    push(0, xs());
    @(negedge core_clk);
    `CHK({keepOut, rxDataFull, rxStsFull}, 3'b100)
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK({keepOut, txStsFull}, 2'b00)
    $display("test resets done");
    wrapUp();
  end
endmodule

// ==== logic/hfp_pkg.sv ====
// Shared constants of the host FIFO port block.
package hfp_pkg;

  // Host byte-address width; bit 1 selects the upper half of a word.
  localparam int          HOST_AW      = 8;

  // Word offsets of the host ports and registers.
  localparam logic [7:0]  OFS_RXDATA   = 8'h00;  // 16 aliased words, 00h to 3Ch.
  localparam logic [7:0]  OFS_TXDATA   = 8'h40;  // 16 aliased words, 40h to 7Ch.
  localparam logic [7:0]  OFS_RXSTS    = 8'h80;  // Receive status, popping port.
  localparam logic [7:0]  OFS_RXPEEK   = 8'h84;  // Receive status, peek port.
  localparam logic [7:0]  OFS_TXSTS    = 8'h88;  // Transmit status, popping port.
  localparam logic [7:0]  OFS_TXPEEK   = 8'h8C;  // Transmit status, peek port.
  localparam logic [7:0]  OFS_FLAGS    = 8'h90;  // Sticky event flags.
  localparam logic [7:0]  OFS_CTRL     = 8'h94;  // Control and FIFO limits.
  localparam logic [7:0]  OFS_ID       = 8'h98;  // Read-only identity word.
  localparam logic [7:0]  OFS_CMD      = 8'h9C;  // Write-only command word.

  // Field positions of the flag register.
  localparam int          FLG_W1C      = 0;      // Receive data overrun, write one to clear.
  localparam int          FLG_RC       = 1;      // Transmit status overrun, clear on read.
  localparam int          FLG_LH       = 2;      // Link event, latched high.
  localparam int          FLG_LL       = 3;      // Link up, latched low.
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;

  // Field positions and reset values of the control register.
  localparam int          CTL_SRST     = 0;      // Auto-clearing software reset.
  localparam int          CTL_KEEP     = 1;      // Survives a software reset.
  localparam int          CTL_DLIM_LSB = 8;      // Data FIFO limit in words, 8 bits.
  localparam int          CTL_SLIM_LSB = 16;     // Receive status limit in entries, 8 bits.
  localparam logic [7:0]  DLIM_RESET   = 8'h40;
  localparam logic [7:0]  SLIM_RESET   = 8'h10;
  localparam logic        KEEP_RESET   = 1'b0;

  // Bits of the write-only command word.
  localparam int          CMD_FLUSH_RX = 0;
  localparam int          CMD_FLUSH_TX = 1;

  // Arbitrary identity value, not tied to any real part.
  localparam logic [31:0] CHIP_ID      = 32'h0000_A5A5;

  // Half-word pairing states.
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RDHI = 3'b010,
    HS_WRHI = 3'b100
  } hfp_half_t;

endpackage

// ==== logic/hfp_port.sv ====
`timescale 1ns/10ps

// One FIFO of flip-flops with a software limit on its fill level.
module hfp_fifo #(
  parameter int W  = 32,  // Word width.
  parameter int AW = 4    // Log2 of the depth.
) (
  input  wire logic          clk,       // System clock.
  input  wire logic          rstN,      // Synchronous reset, active low.
  input  wire logic          clkEn,     // Freezes all state while low.
  input  wire logic          clear,     // Empties the FIFO.
  input  wire logic          push,      // Write request.
  input  wire logic [W-1:0]  pushData,  // Write data.
  input  wire logic          pop,       // Removes the head entry.
  input  wire logic [7:0]    limit,     // Fill level at which it counts as full.
  output logic      [W-1:0]  head,      // Head entry.
  output logic               full,      // Fill level reached the limit.
  output logic               empty      // Nothing stored.
);

  logic [W-1:0]  mem [2**AW];  // Storage.
  logic [AW-1:0] wrPtr;        // Next write slot.
  logic [AW-1:0] rdPtr;        // Head slot.
  logic [AW:0]   count;        // Fill level.
  logic [AW-1:0] next_wrPtr;
  logic [AW-1:0] next_rdPtr;
  logic [AW:0]   next_count;
  logic          doPush;
  logic          doPop;

  // The head is read out of the storage array, forced to zero while empty.
  assign head = empty ? '0 : mem[rdPtr];

  // Pointer and level update; a full FIFO drops pushes, an empty one ignores pops.
  always_comb begin
    doPush     = push & ~full;
    doPop      = pop & ~empty;
    next_wrPtr = wrPtr + AW'(doPush);
    next_rdPtr = rdPtr + AW'(doPop);
    next_count = count + (AW+1)'(doPush) - (AW+1)'(doPop);
    if (clear) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end
  end

  // Registers; full and empty are kept as flops of the next level.
  always_ff @(posedge clk) begin
    if (!rstN) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      full  <= 1'b0;
      empty <= 1'b1;
    end else if (clkEn) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      full  <= (9'(next_count) >= {1'b0, limit}) || (next_count[AW] == 1'b1);
      empty <= (next_count == '0);
      if (doPush && !clear) begin
        mem[wrPtr] <= pushData;
      end
    end
  end

endmodule

// Behaviour
// - Writes to read-only fields change nothing.
// - Reads of write-only words return zero.
// - Writing one clears the flag; zero keeps.
// - Clear-on-read flags clear when read.
// - Latched flags hold until read; then the high one clears and the low one reloads the link level.
// - Keep bit survives software reset.
// - System reset restores all defaults.
// - Words travel as two 16-bit halves.
// - Four FIFOs, three sizes limited by register.
// - Receive FIFOs refuse host writes.
// - Receive status port read pops head.
// - Receive status peek keeps head.
// - Receive data read pops head word.
// - Receive data answers at sixteen aliases.
// - Transmit status port read pops head.
// - Transmit status peek keeps head.
// - Transmit data is write only.
// - Transmit data accepts at sixteen aliases.
module hfp_port
  import hfp_pkg::*;
#(
  parameter int DATA_AW = 6,  // Log2 depth of each data FIFO.
  parameter int STS_AW  = 4   // Log2 depth of each status FIFO.
) (
  input  wire logic               core_clk,     // System clock, 20 MHz.
  input  wire logic               reset_n,      // System and power-on reset.
  input  wire logic               clkEn,        // Freezes all state while low.
  input  wire logic               softResetIn,  // Software reset request pulse.
  input  wire logic               hostRead,     // Half-word read pulse.
  input  wire logic               hostWrite,    // Half-word write pulse.
  input  wire logic [HOST_AW-1:0] hostAddr,     // Byte address; bit 1 picks the half.
  input  wire logic [15:0]        hostWrData,   // Write half-word.
  output logic      [15:0]        hostRdData,   // Read half-word.
  output logic                    hostRdValid,  // Read answer pulse.
  input  wire logic               rxStsPush,    // Receive status entry in.
  input  wire logic [31:0]        rxStsIn,      // Receive status word.
  output logic                    rxStsFull,    // Receive status FIFO at limit.
  input  wire logic               rxDataPush,   // Receive data word in.
  input  wire logic [31:0]        rxDataIn,     // Receive data word.
  output logic                    rxDataFull,   // Receive data FIFO at limit.
  input  wire logic               txStsPush,    // Transmit status entry in.
  input  wire logic [31:0]        txStsIn,      // Transmit status word.
  output logic                    txStsFull,    // Transmit status FIFO at limit.
  output logic                    txDataEmpty,  // No transmit word waiting.
  output logic      [31:0]        txDataOut,    // Head transmit word.
  input  wire logic               txDataTake,   // Removes the head transmit word.
  input  wire logic               linkEvent,    // Link change event.
  input  wire logic               linkUp,       // Link level.
  output logic                    keepOut       // Control bit kept over soft reset.
);

  hfp_half_t      state;       // Half-word pairing state.
  hfp_half_t      next_state;
  logic [7:0]     savedAddr;   // Word address of the pending pair.
  logic [7:0]     next_savedAddr;
  logic [31:0]    hold;        // Word held between the halves.
  logic [31:0]    next_hold;
  logic [15:0]    next_hostRdData;
  logic           next_hostRdValid;
  logic [3:0]     flags;       // Sticky flags.
  logic [3:0]     next_flags;
  logic [7:0]     dataLim;     // Data FIFO limit.
  logic [7:0]     next_dataLim;
  logic [7:0]     stsLim;      // Receive status limit.
  logic [7:0]     next_stsLim;
  logic           next_keepOut;
  logic           softRst;     // Registered software reset pulse.
  logic           next_softRst;
  logic           flushRx;     // Registered receive flush pulse.
  logic           next_flushRx;
  logic           flushTx;     // Registered transmit flush pulse.
  logic           next_flushTx;
  logic [7:0]     wordAddr;    // Current word address.
  logic           rdLow;       // Lower half read.
  logic           rdHigh;      // Upper half read finishing a pair.
  logic           wrLow;       // Lower half write.
  logic           wrHigh;      // Upper half write finishing a pair.
  logic [31:0]    liveWord;    // Word visible at the current address.
  logic [31:0]    wrWord;      // Word completed by an upper half write.
  logic           inRxData;    // Saved address in the receive data window.
  logic           inTxData;    // Saved address in the transmit data window.
  logic           rxStsPop;
  logic           rxDataPop;
  logic           txStsPop;
  logic           txDataPush;
  logic           rdClr;       // Read of the flag word.
  logic           w1cClr;      // Write of one to the write-one-clear flag.
  logic           anyRst;      // Reset of the FIFO contents.
  logic [31:0]    rxStsHead;
  logic [31:0]    rxDataHead;
  logic [31:0]    txStsHead;
  logic           rxStsEmpty;
  logic           rxDataEmpty;
  logic           txStsEmpty;

  // Address qualification; a read wins when both strobes arrive together.
  always_comb begin
    wordAddr = {hostAddr[7:2], 2'b00};
    rdLow    = hostRead & ~hostAddr[1];
    rdHigh   = hostRead & hostAddr[1] & (state == HS_RDHI);
    wrLow    = hostWrite & ~hostRead & ~hostAddr[1];
    wrHigh   = hostWrite & ~hostRead & hostAddr[1] & (state == HS_WRHI);
    wrWord   = {hostWrData, hold[15:0]};
    inRxData = (savedAddr[7:6] == OFS_RXDATA[7:6]);
    inTxData = (savedAddr[7:6] == OFS_TXDATA[7:6]);
    rdClr    = rdLow & (wordAddr == OFS_FLAGS);
    w1cClr   = wrHigh & (savedAddr == OFS_FLAGS) & hold[FLG_W1C];
    anyRst   = softRst;
  end

  // Word decode; write-only words and unused offsets read as zero.
  always_comb begin
    liveWord = 32'h0000_0000;
    if (wordAddr[7:6] == OFS_RXDATA[7:6]) begin
      liveWord = rxDataHead;
    end else begin
      case (wordAddr)
        OFS_RXSTS, OFS_RXPEEK: liveWord = rxStsHead;
        OFS_TXSTS, OFS_TXPEEK: liveWord = txStsHead;
        OFS_FLAGS:             liveWord = {28'h000_0000, flags};
        OFS_CTRL:              liveWord = {8'h00, stsLim, dataLim, 6'h00, keepOut, 1'b0};
        OFS_ID:                liveWord = CHIP_ID;
        default:               liveWord = 32'h0000_0000;
      endcase
    end
  end

  // FIFO strobes fire only when the upper half completes the pair.
  always_comb begin
    rxStsPop   = rdHigh & (savedAddr == OFS_RXSTS);
    rxDataPop  = rdHigh & inRxData;
    txStsPop   = rdHigh & (savedAddr == OFS_TXSTS);
    txDataPush = wrHigh & inTxData;
  end

  // Next values of the host side, control and flags.
  always_comb begin
    next_state       = state;
    next_savedAddr   = savedAddr;
    next_hold        = hold;
    next_hostRdData  = hostRdData;
    next_hostRdValid = 1'b0;
    next_dataLim     = dataLim;
    next_stsLim      = stsLim;
    next_keepOut     = keepOut;
    next_softRst     = softResetIn;
    next_flushRx     = 1'b0;
    next_flushTx     = 1'b0;
    // Sticky flags: an event in the clearing cycle wins.
    next_flags[FLG_W1C] = (rxDataPush & rxDataFull) | (flags[FLG_W1C] & ~w1cClr);
    next_flags[FLG_RC]  = (txStsPush & txStsFull) | (flags[FLG_RC] & ~rdClr);
    next_flags[FLG_LH]  = linkEvent | (flags[FLG_LH] & ~rdClr);
    next_flags[FLG_LL]  = rdClr ? linkUp : (flags[FLG_LL] & linkUp);
    if (rdLow) begin
      // Lower half: capture the whole word so both halves match.
      next_hold        = liveWord;
      next_hostRdData  = liveWord[15:0];
      next_hostRdValid = 1'b1;
      next_savedAddr   = wordAddr;
      next_state       = HS_RDHI;
    end else if (hostRead) begin
      // Upper half: the held word when paired, the live word otherwise.
      next_hostRdData  = rdHigh ? hold[31:16] : liveWord[31:16];
      next_hostRdValid = 1'b1;
      next_state       = HS_IDLE;
    end else if (wrLow) begin
      next_hold[15:0] = hostWrData;
      next_savedAddr  = wordAddr;
      next_state      = HS_WRHI;
    end else if (wrHigh) begin
      next_state = HS_IDLE;
      // Only control and command are decoded here; read-only words ignore it.
      case (savedAddr)
        OFS_CTRL: begin
          next_keepOut = wrWord[CTL_KEEP];
          next_dataLim = wrWord[CTL_DLIM_LSB +: 8];
          next_stsLim  = wrWord[CTL_SLIM_LSB +: 8];
          next_softRst = softResetIn | wrWord[CTL_SRST];
        end
        OFS_CMD: begin
          next_flushRx = wrWord[CMD_FLUSH_RX];
          next_flushTx = wrWord[CMD_FLUSH_TX];
        end
        default: begin
          next_state = HS_IDLE;
        end
      endcase
    end else if (hostWrite) begin
      next_state = HS_IDLE;
    end
    // Software reset restores defaults, sparing only the keep bit.
    if (softRst) begin
      next_state       = HS_IDLE;
      next_savedAddr   = 8'h00;
      next_hold        = 32'h0000_0000;
      next_hostRdData  = 16'h0000;
      next_hostRdValid = 1'b0;
      next_flags       = FLAGS_RESET;
      next_dataLim     = DLIM_RESET;
      next_stsLim      = SLIM_RESET;
      next_keepOut     = keepOut;
      next_softRst     = 1'b0;
      next_flushRx     = 1'b0;
      next_flushTx     = 1'b0;
    end
  end

  // Registers; the system reset restores every default.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state       <= HS_IDLE;
      savedAddr   <= 8'h00;
      hold        <= 32'h0000_0000;
      hostRdData  <= 16'h0000;
      hostRdValid <= 1'b0;
      flags       <= FLAGS_RESET;
      dataLim     <= DLIM_RESET;
      stsLim      <= SLIM_RESET;
      keepOut     <= KEEP_RESET;
      softRst     <= 1'b0;
      flushRx     <= 1'b0;
      flushTx     <= 1'b0;
    end else if (clkEn) begin
      state       <= next_state;
      savedAddr   <= next_savedAddr;
      hold        <= next_hold;
      hostRdData  <= next_hostRdData;
      hostRdValid <= next_hostRdValid;
      flags       <= next_flags;
      dataLim     <= next_dataLim;
      stsLim      <= next_stsLim;
      keepOut     <= next_keepOut;
      softRst     <= next_softRst;
      flushRx     <= next_flushRx;
      flushTx     <= next_flushTx;
    end
  end

  // The four FIFOs; receive status and data depths are capped by the control word, transmit status is fixed at SLIM_RESET.
  hfp_fifo #(.W(32), .AW(STS_AW)) rxStsFifo (
    .clk(core_clk), .rstN(reset_n), .clkEn(clkEn), .clear(anyRst),
    .push(rxStsPush), .pushData(rxStsIn), .pop(rxStsPop), .limit(stsLim),
    .head(rxStsHead), .full(rxStsFull), .empty(rxStsEmpty));
  hfp_fifo #(.W(32), .AW(DATA_AW)) rxDataFifo (
    .clk(core_clk), .rstN(reset_n), .clkEn(clkEn), .clear(anyRst | flushRx),
    .push(rxDataPush), .pushData(rxDataIn), .pop(rxDataPop), .limit(dataLim),
    .head(rxDataHead), .full(rxDataFull), .empty(rxDataEmpty));
  hfp_fifo #(.W(32), .AW(STS_AW)) txStsFifo (
    .clk(core_clk), .rstN(reset_n), .clkEn(clkEn), .clear(anyRst),
    .push(txStsPush), .pushData(txStsIn), .pop(txStsPop), .limit(SLIM_RESET),
    .head(txStsHead), .full(txStsFull), .empty(txStsEmpty));
  hfp_fifo #(.W(32), .AW(DATA_AW)) txDataFifo (
    .clk(core_clk), .rstN(reset_n), .clkEn(clkEn), .clear(anyRst | flushTx),
    .push(txDataPush), .pushData(wrWord), .pop(txDataTake), .limit(dataLim),
    .head(txDataOut), .full(), .empty(txDataEmpty));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Steps of a paired access.
  sequence sPeekHigh;
    clkEn && rdHigh && (savedAddr == OFS_RXPEEK) && !rxStsPush && !softRst;
  endsequence
  sequence sLowData;
    clkEn && rdLow && (wordAddr[7:6] == 2'b00) && !rxDataPush && !softRst;
  endsequence

  a_wo_reads_zero: assert property (
    clkEn && hostRead && (wordAddr == OFS_CMD) && !softRst |=> hostRdValid && hostRdData == 16'h0000)
    else $error("Write-only word read as non-zero.");
  a_w1c_one_clears: assert property (
    clkEn && w1cClr && !rxDataPush && !softRst |=> !flags[FLG_W1C])
    else $error("Write of one left the flag set.");
  a_w1c_zero_keeps: assert property (
    clkEn && flags[FLG_W1C] && !softRst |=> flags[FLG_W1C] || $past(w1cClr))
    else $error("Flag cleared without a write of one.");
  a_read_clears_flag: assert property (
    clkEn && rdClr && !txStsPush && !linkEvent && !softRst |=> !flags[FLG_RC] && !flags[FLG_LH])
    else $error("Read did not clear the flag.");
  a_latch_holds: assert property (
    clkEn && flags[FLG_LH] && !rdClr && !softRst |=> flags[FLG_LH])
    else $error("Latched flag dropped without a read.");
  a_keep_soft_reset: assert property (
    clkEn && softRst |=> keepOut == $past(keepOut))
    else $error("Keep bit changed on software reset.");
  a_soft_defaults: assert property (
    clkEn && softRst |=> dataLim == DLIM_RESET && stsLim == SLIM_RESET && state == HS_IDLE)
    else $error("Software reset left a non-default value.");
  a_peek_keeps_head: assert property (
    sPeekHigh and !rxStsEmpty |=> rxStsHead == $past(rxStsHead) && !rxStsEmpty)
    else $error("Peek removed the head entry.");
  a_low_no_pop: assert property (
    sLowData and !rxDataEmpty |=> rxDataHead == $past(rxDataHead))
    else $error("Lower half read popped the data FIFO.");
  a_low_then_high: assert property (
    sLowData |=> state == HS_RDHI && hostRdData == $past(liveWord[15:0]))
    else $error("Lower half read did not arm the pair.");

endmodule
